// File: hdl/synth_consts.vh
`ifndef SYNTH_CONSTS_VH
`define SYNTH_CONSTS_VH
// timing
`define CLK_HZ 20000000
`define SETTLE_TIME_MS 50
`define SETTLE_CYC (`SETTLE_TIME_MS * (`CLK_HZ / 1000))
`define SCLK_HALF 4
`define LOCK_WAIT_RST 32'h00004e20
// host register word addresses
`define A_CTRL 4'h0
`define A_STATUS 4'h1
`define A_IRQ_STAT 4'h2
`define A_IRQ_MASK 4'h3
`define A_CFG 4'h4
`define A_SWEEP_INC 4'h5
`define A_SWEEP_STEPS 4'h6
`define A_LOCK_WAIT 4'h7
`define A_DEV_STAT 4'h8
`define A_DEV_ID 4'h9
`define A_REC_IDX 4'ha
`define A_REC_DATA 4'hb
`define A_MAN_PAIR 4'hc
// control command bits
`define CMD_INIT 0
`define CMD_SWEEP 1
`define CMD_MANUAL 2
// interrupt bits
`define IRQ_INIT 0
`define IRQ_SWEEP 1
`define IRQ_MANUAL 2
`define IRQ_UNLOCK 3
`define IRQ_FULL 4
`define IRQ_W 5
// device register addresses
`define DEV_MAIN 4'h0
`define DEV_CAL 4'h1
`define DEV_OSC 4'h6
`define DEV_REGUL 4'h8
`define DEV_TEST 4'h9
`define DEV_LSTAT 4'ha
`define DEV_PID 4'hb
// serial word layout
`define RD_BIT 31
`define ADDR_HI 30
`define ADDR_LO 27
// device status fields
`define ST_LOCK 7
`define ST_PAIR_HI 6
`define ST_PAIR_LO 0
// manual calibration fields
`define MAN_EN_BIT 26
`define OSC_PAIR_LO 0
`endif

// File: hdl/cal_record_mem.v
module cal_record_mem #(
  parameter W = 18,
  parameter AW = 6
) (
  input wire clk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [W-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [W-1:0] rdata
);
  reg [W-1:0] mem [0:(1<<AW)-1];

  // write port and registered read port
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// File: hdl/serial_word_master.v
`include "synth_consts.vh"
module serial_word_master #(
  parameter HALF = `SCLK_HALF
) (
  input wire clk,
  input wire rst_n,
  input wire go,
  input wire rd,
  input wire [31:0] word,
  input wire sdo_pin,
  output reg sclk,
  output reg le_n,
  output reg sdi,
  output reg [26:0] rdata,
  output reg done,
  output wire sdo_sync
);
  reg busy_r;
  reg rd_r;
  reg [7:0] div_r;
  reg [5:0] bit_r;
  reg [31:0] sh_r;
  reg s1_r;
  reg s2_r;

  assign sdo_sync = s2_r;

  // two-stage synchroniser for the shared lock / read-data pin
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= sdo_pin;
      s2_r <= s1_r;
    end
  end

  // msb-first shifter, sdi changes while sclk low, sdo taken at end of high phase
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      rd_r <= 1'b0;
      div_r <= 8'h00;
      bit_r <= 6'h00;
      sh_r <= 32'h00000000;
      sclk <= 1'b0;
      le_n <= 1'b1;
      sdi <= 1'b0;
      rdata <= 27'h0000000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy_r) begin
        if (go) begin
          busy_r <= 1'b1;
          rd_r <= rd;
          sh_r <= word;
          sdi <= word[31];
          le_n <= 1'b0;
          bit_r <= 6'h00;
          div_r <= 8'h00;
        end
      end else if (div_r != HALF[7:0] - 8'h01) begin
        div_r <= div_r + 8'h01;
      end else begin
        div_r <= 8'h00;
        sclk <= ~sclk;
        if (sclk) begin
          if (rd_r && bit_r >= 6'h05) begin
            rdata <= {rdata[25:0], s2_r};
          end
          if (bit_r == 6'h1f) begin
            busy_r <= 1'b0;
            le_n <= 1'b1;
            done <= 1'b1;
            sdi <= 1'b0;
          end else begin
            bit_r <= bit_r + 6'h01;
            sh_r <= {sh_r[30:0], 1'b0};
            sdi <= sh_r[30];
          end
        end
      end
    end
  end
endmodule

// File: hdl/synth_powerup_cal_sequencer.v
// Operation
// (R1) wait at least 50 ms after supplies settle before going on
// (R2) device keeps only its regulators up until programmed
// (R3) enable reference clock after settle wait, before first programming
// (R4) first write goes to test register with all data bits zero
// (R5) next write goes to main divider register 0
// (R6) then write registers 8 down to 1, finishing with register 0
// (R7) after programming check lock and read status and identity registers
// (R8) device identity register at 0x0b returns a 27-bit part identifier
// (R9) every serial word carries register address together with data
// (R10) word: bit 31 clear, address in 30:27, data in 26:0
// (R11) sweep steps the oscillator in 5 MHz or smaller increments
// (R12) each sweep step: wait lock time, read lock, band, sub-band
// (R13) store first step always, later only when band/sub-band changes
// (R14) field setup: manual calibration bit in register 1, pair into register 6
// (R15) sweep records are produced separately for each part
// (R16) status: bit 7 lock, bits 6:5 band, bits 4:0 sub-band
// (R17) device switches its lock pin to read data during reads
// (R18) settle and lock waits are timed from own clock after reset
`include "synth_consts.vh"
module synth_powerup_cal_sequencer #(
  parameter SETTLE_CYC = `SETTLE_CYC,
  parameter REC_AW = 6
) (
  input wire clk,
  input wire rst_n,
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  output reg irq,
  output reg ref_clk_en,
  output wire spi_sclk,
  output wire spi_le_n,
  output wire spi_sdi,
  input wire lock_serial_out_pin
);
  localparam S_SETTLE = 7'h01;
  localparam S_IDLE = 7'h02;
  localparam S_FETCH = 7'h04;
  localparam S_WR = 7'h08;
  localparam S_LOCKW = 7'h10;
  localparam S_RDST = 7'h20;
  localparam S_RDID = 7'h40;
  localparam M_INIT = 2'd0;
  localparam M_SWEEP = 2'd1;
  localparam M_MAN = 2'd2;
  localparam IRQ_W_L = `IRQ_W;

  reg [6:0] state_r;
  reg [1:0] mode_r;
  reg [3:0] idx_r;
  reg issued_r;
  reg [31:0] cnt_r;
  reg [IRQ_W_L-1:0] irq_stat_r;
  reg [IRQ_W_L-1:0] irq_mask_r;
  reg [26:0] sweep_inc_r;
  reg [26:0] sweep_acc_r;
  reg [9:0] sweep_steps_r;
  reg [9:0] step_r;
  reg [31:0] lock_wait_r;
  reg [26:0] dev_stat_r;
  reg [26:0] dev_id_r;
  reg [REC_AW-1:0] rec_idx_r;
  reg [REC_AW:0] rec_cnt_r;
  reg [6:0] prev_pair_r;
  reg [6:0] man_pair_r;
  reg spi_go_r;
  reg spi_rd_r;
  reg [31:0] spi_word_r;
  reg [IRQ_W_L-1:0] irq_set;
  reg [3:0] tgt_addr;
  reg last_wr;
  reg [26:0] wr_data;
  reg rec_we;
  wire [26:0] cfg_rdata;
  wire [17:0] rec_rdata;
  wire [26:0] spi_rdata;
  wire spi_done;
  wire lock_sync;
  wire bus_req;
  wire bus_wr;
  wire idle;

  assign bus_req = (read | write) & waitrequest;
  assign bus_wr = write & waitrequest;
  assign idle = (state_r == S_IDLE);

  // target device register for the current list entry
  always @* begin
    tgt_addr = `DEV_MAIN;
    last_wr = 1'b1;
    case (mode_r)
      M_INIT: begin
        last_wr = (idx_r == 4'd10);
        if (idx_r == 4'd0) begin
          tgt_addr = `DEV_TEST; // R4
        end else if (idx_r == 4'd1 || idx_r == 4'd10) begin
          tgt_addr = `DEV_MAIN; // R5 R6
        end else begin
          tgt_addr = 4'd10 - idx_r; // R6
        end
      end
      M_MAN: begin
        last_wr = (idx_r == 4'd2);
        if (idx_r == 4'd0) begin
          tgt_addr = `DEV_OSC;
        end else if (idx_r == 4'd1) begin
          tgt_addr = `DEV_CAL;
        end else begin
          tgt_addr = `DEV_MAIN;
        end
      end
      default: begin
        tgt_addr = `DEV_MAIN;
        last_wr = 1'b1;
      end
    endcase
  end

  // data for the write, built from the stored configuration word, except the all-zero test register word
  always @* begin
    wr_data = cfg_rdata;
    if (tgt_addr == `DEV_TEST) begin
      wr_data = 27'h0000000; // R4
    end else if (mode_r == M_SWEEP) begin
      wr_data = cfg_rdata + sweep_acc_r; // R11
    end else if (mode_r == M_MAN && tgt_addr == `DEV_OSC) begin
      wr_data[`OSC_PAIR_LO+6:`OSC_PAIR_LO] = man_pair_r; // R14
    end else if (mode_r == M_MAN && tgt_addr == `DEV_CAL) begin
      wr_data[`MAN_EN_BIT] = 1'b1; // R14
    end
  end

  // configuration words, written by software in serial word layout
  cal_record_mem #(
    .W(27),
    .AW(4)
  ) u_cfg (
    .clk(clk),
    .we(bus_wr && address == `A_CFG),
    .waddr(writedata[`ADDR_HI:`ADDR_LO]),
    .wdata(writedata[26:0]),
    .raddr(tgt_addr),
    .rdata(cfg_rdata)
  );

  // sweep records: step index, lock, band, sub-band
  cal_record_mem #(
    .W(18),
    .AW(REC_AW)
  ) u_rec (
    .clk(clk),
    .we(rec_we),
    .waddr(rec_cnt_r[REC_AW-1:0]),
    .wdata({step_r, spi_rdata[`ST_LOCK], spi_rdata[`ST_PAIR_HI:`ST_PAIR_LO]}),
    .raddr(rec_idx_r),
    .rdata(rec_rdata)
  );

  serial_word_master #(
    .HALF(`SCLK_HALF)
  ) u_spi (
    .clk(clk),
    .rst_n(rst_n),
    .go(spi_go_r),
    .rd(spi_rd_r),
    .word(spi_word_r),
    .sdo_pin(lock_serial_out_pin),
    .sclk(spi_sclk),
    .le_n(spi_le_n),
    .sdi(spi_sdi),
    .rdata(spi_rdata),
    .done(spi_done),
    .sdo_sync(lock_sync)
  );

  // record stored on first step or when the pair changes
  always @* begin
    rec_we = 1'b0;
    if (state_r == S_RDST && issued_r && spi_done && mode_r == M_SWEEP) begin
      if ((step_r == 10'd0 || spi_rdata[6:0] != prev_pair_r) && !rec_cnt_r[REC_AW]) begin
        rec_we = 1'b1; // R13
      end
    end
  end

  // sequencer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_SETTLE;
      mode_r <= M_INIT;
      idx_r <= 4'd0;
      issued_r <= 1'b0;
      cnt_r <= 32'h00000000;
      ref_clk_en <= 1'b0;
      spi_go_r <= 1'b0;
      spi_rd_r <= 1'b0;
      spi_word_r <= 32'h00000000;
      sweep_acc_r <= 27'h0000000;
      step_r <= 10'd0;
      rec_cnt_r <= {(REC_AW+1){1'b0}};
      prev_pair_r <= 7'h00;
      dev_stat_r <= 27'h0000000;
      dev_id_r <= 27'h0000000;
      irq_set <= {IRQ_W_L{1'b0}};
    end else begin
      spi_go_r <= 1'b0;
      irq_set <= {IRQ_W_L{1'b0}};
      case (state_r)
        S_SETTLE: begin
          if (cnt_r == SETTLE_CYC - 1) begin // R1 R18
            ref_clk_en <= 1'b1; // R3
            state_r <= S_IDLE;
          end else begin
            cnt_r <= cnt_r + 32'h00000001;
          end
        end
        S_IDLE: begin
          idx_r <= 4'd0;
          issued_r <= 1'b0;
          if (bus_wr && address == `A_CTRL) begin
            if (writedata[`CMD_INIT]) begin
              mode_r <= M_INIT;
              state_r <= S_FETCH;
            end else if (writedata[`CMD_SWEEP] && sweep_steps_r != 10'd0) begin
              mode_r <= M_SWEEP; // R15
              step_r <= 10'd0;
              sweep_acc_r <= 27'h0000000;
              rec_cnt_r <= {(REC_AW+1){1'b0}};
              state_r <= S_FETCH;
            end else if (writedata[`CMD_MANUAL]) begin
              mode_r <= M_MAN;
              state_r <= S_FETCH;
            end
          end
        end
        S_FETCH: begin
          state_r <= S_WR; // memory read latency
        end
        S_WR: begin
          if (!issued_r) begin
            spi_go_r <= 1'b1;
            spi_rd_r <= 1'b0;
            spi_word_r <= {1'b0, tgt_addr, wr_data}; // R9 R10
            issued_r <= 1'b1;
          end else if (spi_done) begin
            issued_r <= 1'b0;
            if (last_wr) begin
              cnt_r <= 32'h00000000;
              state_r <= S_LOCKW;
            end else begin
              idx_r <= idx_r + 4'd1;
              state_r <= S_FETCH;
            end
          end
        end
        S_LOCKW: begin
          if (cnt_r >= lock_wait_r) begin // R12 R18
            state_r <= S_RDST;
          end else begin
            cnt_r <= cnt_r + 32'h00000001;
          end
        end
        S_RDST: begin
          if (!issued_r) begin
            spi_go_r <= 1'b1;
            spi_rd_r <= 1'b1; // R17
            spi_word_r <= {1'b1, `DEV_LSTAT, 27'h0000000}; // R7
            issued_r <= 1'b1;
          end else if (spi_done) begin
            issued_r <= 1'b0;
            dev_stat_r <= spi_rdata;
            irq_set[`IRQ_UNLOCK] <= ~spi_rdata[`ST_LOCK]; // R16
            if (mode_r == M_INIT) begin
              state_r <= S_RDID;
            end else if (mode_r == M_MAN) begin
              irq_set[`IRQ_MANUAL] <= 1'b1;
              state_r <= S_IDLE;
            end else begin
              prev_pair_r <= spi_rdata[`ST_PAIR_HI:`ST_PAIR_LO]; // R12
              if (rec_we) begin
                rec_cnt_r <= rec_cnt_r + 1'b1;
              end else if (rec_cnt_r[REC_AW]) begin
                irq_set[`IRQ_FULL] <= 1'b1;
              end
              if (step_r == sweep_steps_r - 10'd1) begin
                irq_set[`IRQ_SWEEP] <= 1'b1;
                state_r <= S_IDLE;
              end else begin
                step_r <= step_r + 10'd1;
                sweep_acc_r <= sweep_acc_r + sweep_inc_r; // R11
                state_r <= S_FETCH;
              end
            end
          end
        end
        S_RDID: begin
          if (!issued_r) begin
            spi_go_r <= 1'b1;
            spi_rd_r <= 1'b1;
            spi_word_r <= {1'b1, `DEV_PID, 27'h0000000}; // R7 R8
            issued_r <= 1'b1;
          end else if (spi_done) begin
            issued_r <= 1'b0;
            dev_id_r <= spi_rdata;
            irq_set[`IRQ_INIT] <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // avalon slave: one wait cycle, then answer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
      irq_stat_r <= {IRQ_W_L{1'b0}};
      irq_mask_r <= {IRQ_W_L{1'b0}};
      sweep_inc_r <= 27'h0000000;
      sweep_steps_r <= 10'd0;
      lock_wait_r <= `LOCK_WAIT_RST;
      rec_idx_r <= {REC_AW{1'b0}};
      man_pair_r <= 7'h00;
      irq <= 1'b0;
    end else begin
      waitrequest <= ~bus_req;
      irq <= |(irq_stat_r & irq_mask_r);
      // set wins over a write-one clear in the same cycle
      if (bus_wr && address == `A_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~writedata[IRQ_W_L-1:0]) | irq_set;
      end else begin
        irq_stat_r <= irq_stat_r | irq_set;
      end
      if (bus_wr) begin
        case (address)
          `A_IRQ_MASK: irq_mask_r <= writedata[IRQ_W_L-1:0];
          `A_SWEEP_INC: sweep_inc_r <= writedata[26:0];
          `A_SWEEP_STEPS: sweep_steps_r <= writedata[9:0];
          `A_LOCK_WAIT: lock_wait_r <= writedata;
          `A_REC_IDX: rec_idx_r <= writedata[REC_AW-1:0];
          `A_MAN_PAIR: man_pair_r <= writedata[6:0];
          default: begin
          end
        endcase
      end
      readdata <= 32'h00000000;
      if (read && waitrequest) begin
        case (address)
          `A_CTRL: readdata <= {25'h0000000, state_r};
          `A_STATUS: readdata <= {{(28-REC_AW){1'b0}}, rec_cnt_r, ~idle, ref_clk_en, lock_sync};
          `A_IRQ_STAT: readdata <= {{(32-IRQ_W_L){1'b0}}, irq_stat_r};
          `A_IRQ_MASK: readdata <= {{(32-IRQ_W_L){1'b0}}, irq_mask_r};
          `A_SWEEP_INC: readdata <= {5'h00, sweep_inc_r};
          `A_SWEEP_STEPS: readdata <= {22'h000000, sweep_steps_r};
          `A_LOCK_WAIT: readdata <= lock_wait_r;
          `A_DEV_STAT: readdata <= {5'h00, dev_stat_r};
          `A_DEV_ID: readdata <= {5'h00, dev_id_r};
          `A_REC_IDX: readdata <= {{(32-REC_AW){1'b0}}, rec_idx_r};
          `A_REC_DATA: readdata <= {14'h0000, rec_rdata};
          `A_MAN_PAIR: readdata <= {25'h0000000, man_pair_r};
          default: readdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// File: verif/seq_monitor.sv
module seq_monitor #(
  parameter SETTLE_CYC = 200
) (
  input wire clk,
  input wire rst_n,
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire irq,
  input wire ref_clk_en,
  input wire spi_sclk,
  input wire spi_le_n,
  input wire spi_sdi,
  input wire lock_serial_out_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  int scnt;
  int lcnt;
  // cycles since reset release (saturating) and length of the current frame
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scnt <= 0;
      lcnt <= 0;
    end else begin
      scnt <= (scnt < SETTLE_CYC + 4) ? scnt + 1 : scnt;
      lcnt <= spi_le_n ? 0 : lcnt + 1;
    end
  end
  chk_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no answer");
  chk_wait_pulse: assert property (!waitrequest |=> waitrequest) else $error("waitrequest low too long");
  chk_rdata_zero: assert property (waitrequest |-> readdata == 32'h0) else $error("readdata not zero");
  chk_settle_early: assert property ($rose(ref_clk_en) |-> scnt >= SETTLE_CYC) else $error("early ref");
  chk_settle_late: assert property (scnt == SETTLE_CYC + 4 |-> ref_clk_en) else $error("late ref");
  chk_no_early: assert property (!ref_clk_en |-> spi_le_n && !spi_sclk) else $error("frame before ref");
  chk_sclk_idle: assert property (spi_le_n |-> !spi_sclk) else $error("clock outside frame");
  chk_sclk_high: assert property ($rose(spi_sclk) |-> spi_sclk[*4] ##1 !spi_sclk) else $error("bad high phase");
  chk_le_frame: assert property ($rose(spi_le_n) |-> lcnt == 256) else $error("frame not 32 bits");
  chk_sdi_stable: assert property (spi_sclk && $past(spi_sclk) |-> $stable(spi_sdi)) else $error("data moved");
  cover property ($rose(irq));
  cover property (read && !waitrequest);
  cover property ($rose(spi_le_n));
endmodule
bind synth_powerup_cal_sequencer seq_monitor #(.SETTLE_CYC(SETTLE_CYC)) mon_u (.clk(clk), .rst_n(rst_n),
  .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .irq(irq), .ref_clk_en(ref_clk_en), .spi_sclk(spi_sclk),
  .spi_le_n(spi_le_n), .spi_sdi(spi_sdi), .lock_serial_out_pin(lock_serial_out_pin));

// File: verif/synth_dev_model.sv
module synth_dev_model #(
  parameter logic [26:0] ID_CODE = 27'h0001234 // arbitrary value
) (
  input wire spi_sclk,
  input wire spi_le_n,
  input wire spi_sdi,
  input wire ref_on,
  input wire lock_ok,
  output wire lock_serial_out_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] sh = 32'h0;
  logic [5:0] n = 6'h0;
  logic [26:0] regs [0:15];
  logic [3:0] log_a [0:63];
  logic [26:0] log_d [0:63];
  int nlog = 0;
  logic prog = 1'b0;
  logic rd = 1'b0;
  logic out_r = 1'b0;
  logic [26:0] rq = 27'h0;
  // core stays down, so no lock, until clocked and programmed
  wire lock = lock_ok && ref_on && prog;
  // pair follows the divider setting, one pair per 8 units
  wire [26:0] stat = {19'h0, lock, regs[0][9:3]};
  // shift in on rising clock, store whole write words at latch
  always @(posedge spi_sclk or posedge spi_le_n) begin
    if (spi_le_n) begin
      if (n == 6'd32 && !sh[31]) begin
        regs[sh[30:27]] <= sh[26:0];
        log_a[nlog[5:0]] <= sh[30:27];
        log_d[nlog[5:0]] <= sh[26:0];
        nlog <= nlog + 1;
        prog <= prog || sh[30:27] == 4'h0;
      end
      n <= 6'h0;
    end else begin
      sh <= {sh[30:0], spi_sdi};
      n <= n + 6'd1;
    end
  end
  // read data changes on falling clock so it stands over the next rise
  always @(negedge spi_sclk) begin
    if (n == 6'd5) begin
      rd = sh[4];
      rq = (sh[3:0] == 4'hb) ? ID_CODE : stat;
    end
    if (n >= 6'd5 && n < 6'd32) out_r = rq[31 - n];
  end
  // pin carries read data inside a read frame, lock otherwise
  assign lock_serial_out_pin = (rd && !spi_le_n && n >= 6'd5) ? out_r : lock;
endmodule

// File: verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SC = 200;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic lock_ok = 1'b1;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] rv;
  wire [31:0] readdata;
  wire waitrequest, irq, ref_clk_en, spi_sclk, spi_le_n, spi_sdi, lsop;
  int fails = 0;
  int checks = 0;
  synth_powerup_cal_sequencer #(.SETTLE_CYC(SC)) dut_u (.clk(clk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .irq(irq), .ref_clk_en(ref_clk_en), .spi_sclk(spi_sclk), .spi_le_n(spi_le_n), .spi_sdi(spi_sdi),
    .lock_serial_out_pin(lsop));
  synth_dev_model dev_u (.spi_sclk(spi_sclk), .spi_le_n(spi_le_n), .spi_sdi(spi_sdi), .ref_on(ref_clk_en),
    .lock_ok(lock_ok), .lock_serial_out_pin(lsop));
  initial forever #25 clk = ~clk;
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // one avalon access; holds the request until waitrequest is sampled low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    rv = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (k >= 50) chk("bus", 0, 1);
  endtask
  task wirq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 10000) begin
      @(posedge clk);
      k++;
    end
    chk("irq", 1, irq);
  endtask
  // write one to clear, then the level must drop
  task clr(input logic [31:0] m, input logic e);
    bus(1, 4'h2, m);
    repeat (3) @(posedge clk);
    chk("irq low", e, irq);
  endtask
  function logic [26:0] cfgd(input logic [3:0] a);
    return 27'h40 + {a, 8'h0};
  endfunction
  task t_settle;
    int k;
    bus(0, 4'h0, 0); chk("state", 32'h1, rv);
    bus(0, 4'h7, 0); chk("lock wait", 32'h4e20, rv);
    bus(0, 4'h3, 0); chk("mask", 0, rv);
    k = 0;
    while (ref_clk_en !== 1'b1 && k < 400) begin
      @(posedge clk);
      k++;
    end
    bus(0, 4'h0, 0); chk("idle", 32'h2, rv);
    bus(0, 4'h1, 0); chk("status", 32'h2, rv);
    chk("early words", 0, dev_u.nlog);
    $display("done settle");
  endtask
  task t_init;
    logic [3:0] ea [0:10];
    ea = '{4'h9, 4'h0, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
    bus(1, 4'h7, 10);
    bus(1, 4'h3, 1);
    for (int i = 0; i < 9; i++) bus(1, 4'h4, {1'b0, 4'(i), cfgd(4'(i))});
    bus(1, 4'h0, 1);
    wirq();
    for (int i = 0; i < 11; i++) begin
      chk("addr", ea[i], dev_u.log_a[i]);
      chk("data", (i == 0) ? 0 : cfgd(ea[i]), dev_u.log_d[i]);
    end
    bus(0, 4'h9, 0); chk("id", 27'h0001234, rv);
    bus(0, 4'h8, 0); chk("dev stat", 32'h88, rv);
    bus(0, 4'h1, 0); chk("status", 32'h3, rv);
    bus(0, 4'h2, 0); chk("irq stat", 32'h1, rv);
    clr(1, 0);
    $display("done init");
  endtask
  task t_map;
    bus(1, 4'hd, 32'h5a);
    bus(0, 4'hd, 0); chk("unmapped", 0, rv);
    bus(1, 4'h9, 32'h77);
    bus(0, 4'h9, 0); chk("id ro", 27'h0001234, rv);
    $display("done map");
  endtask
  task t_sweep;
    int b;
    b = dev_u.nlog;
    bus(1, 4'h5, 4);
    bus(1, 4'h6, 4);
    bus(1, 4'h3, 2);
    bus(1, 4'h0, 2);
    wirq();
    chk("words", b + 4, dev_u.nlog);
    for (int i = 0; i < 4; i++) chk("step", 27'h40 + 27'(4 * i), dev_u.log_d[b + i]);
    bus(0, 4'h1, 0); chk("count", 32'h13, rv);
    bus(1, 4'ha, 0);
    repeat (2) @(posedge clk);
    bus(0, 4'hb, 0); chk("rec0", 32'h88, rv);
    bus(1, 4'ha, 1);
    repeat (2) @(posedge clk);
    bus(0, 4'hb, 0); chk("rec1", 32'h289, rv);
    clr(2, 0);
    $display("done sweep");
  endtask
  task t_manual;
    int b;
    b = dev_u.nlog;
    lock_ok <= 1'b0;
    bus(1, 4'hc, 32'h35);
    bus(1, 4'h3, 4);
    bus(1, 4'h0, 4);
    wirq();
    chk("reg6", 27'h635, dev_u.log_d[b]);
    chk("reg1", 27'h4000140, dev_u.log_d[b + 1]);
    chk("reg0", 27'h40, dev_u.log_d[b + 2]);
    chk("a0", 0, dev_u.log_a[b + 2]);
    bus(0, 4'h2, 0); chk("irq stat", 32'hc, rv);
    clr(4, 0);
    bus(0, 4'h2, 0); chk("masked", 32'h8, rv);
    clr(8, 0);
    lock_ok <= 1'b1;
    $display("done manual");
  endtask
  task results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_settle();
    t_init();
    t_map();
    t_sweep();
    t_manual();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end
endmodule
